/* core/dcwd_mon_dec.sv */
// monitor select decoder for one monitor slot
`timescale 1ns/1ps
`default_nettype none
module dcwd_mon_dec (
    input wire logic [3:0] nib,
    input wire logic hi,
    input wire logic ext_cmd,
    output logic ok,
    output logic [4:0] idx
);
    logic [4:0] code_w;
    logic ext_range_w;
    assign code_w = {hi, nib};
    // basic items 0..f always legal, the extended block only up to 16
    assign ext_range_w = (code_w <= dcwd_pkg::MON_LAST_EXT);
    assign ok = hi ? (ext_cmd && ext_range_w) : 1'b1;
    assign idx = ok ? code_w : 5'h00;
endmodule : dcwd_mon_dec
`default_nettype wire

/* core/dcwd_pkg.sv */
// constants, code maps and register map of the drive command word decoder
package dcwd_pkg;
    // command codes
    localparam logic [7:0] CMD_BASIC = 8'h50;
    localparam logic [7:0] CMD_IO = 8'h51;
    localparam logic [7:0] CMD_EXT = 8'h52;
    // drive control word bit positions
    localparam int BIT_FWD = 0;
    localparam int BIT_REV = 1;
    localparam int BIT_FRST = 9;
    localparam int BIT_EXTF = 10;
    localparam int BIT_HCLR = 11;
    localparam int BIT_BBLK = 12;
    localparam int BIT_VIN_LO = 16;
    localparam int VIN_N = 6;
    localparam int VIN_EIGHT = 5;
    localparam logic [31:0] CTRL_USED_MASK = 32'h003f_1e03;
    // reference select codes
    localparam logic [3:0] REF_NONE = 4'h0;
    localparam logic [3:0] REF_TRQ_COMP = 4'h1;
    localparam logic [3:0] REF_AOUT1 = 4'h2;
    localparam logic [3:0] REF_AOUT2 = 4'h3;
    localparam logic [3:0] REF_TERM_OUT = 4'h4;
    localparam logic [3:0] REF_PID_SP = 4'h5;
    localparam logic [3:0] REF_PULSE = 4'h6;
    localparam logic [3:0] REF_VF_GAIN = 4'h7;
    localparam logic [3:0] REF_CMD_SEL = 4'h9;
    localparam int PID_EN_BIT = 1;
    localparam int PARAM_W = 12;
    localparam logic [11:0] AOUT_PARAM_FREE = 12'h000;
    // monitor select codes
    localparam logic [4:0] MON_LAST_EXT = 5'h16;
    localparam int NIB_W = 4;
    // register map, byte addresses
    localparam int ADDR_W = 8;
    localparam logic [7:0] REG_CFG = 8'h00;
    localparam logic [7:0] REG_STAT = 8'h04;
    localparam logic [7:0] REG_ECHO = 8'h08;
    localparam int CFG_AO1_LSB = 0;
    localparam int CFG_AO2_LSB = 12;
    localparam int CFG_S8_BIT = 24;
    localparam logic [31:0] CFG_RST = 32'h0000_0000;
endpackage : dcwd_pkg

/* core/dcwd_ref_dec.sv */
// reference select decoder for one auxiliary reference slot
`timescale 1ns/1ps
`default_nettype none
module dcwd_ref_dec (
    input wire logic [3:0] code,
    input wire logic [11:0] ao1_param,
    input wire logic [11:0] ao2_param,
    input wire logic [15:0] ref_data,
    output logic honour,
    output logic pid_en
);
    always_comb begin
        case (code)
            dcwd_pkg::REF_NONE, dcwd_pkg::REF_TRQ_COMP, dcwd_pkg::REF_TERM_OUT: begin
                honour = 1'b1;
            end
            dcwd_pkg::REF_AOUT1: begin
                honour = (ao1_param == dcwd_pkg::AOUT_PARAM_FREE);
            end
            dcwd_pkg::REF_AOUT2: begin
                honour = (ao2_param == dcwd_pkg::AOUT_PARAM_FREE);
            end
            dcwd_pkg::REF_PID_SP, dcwd_pkg::REF_PULSE, dcwd_pkg::REF_VF_GAIN,
            dcwd_pkg::REF_CMD_SEL: begin
                honour = 1'b1;
            end
            default: begin
                // code 8 and a..f carry nothing
                honour = 1'b0;
            end
        endcase
    end
    assign pid_en = (code == dcwd_pkg::REF_CMD_SEL) && ref_data[dcwd_pkg::PID_EN_BIT];
endmodule : dcwd_ref_dec
`default_nettype wire

/* core/dcwd_top.sv */
// drive command word decoder: control bits, select codes and register port
`timescale 1ns/1ps
`default_nettype none
module dcwd_top (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_code,
    input wire logic [31:0] drive_control_word,
    input wire logic [7:0] aux_reference_select_pair,
    input wire logic [7:0] monitor_value_select_pair,
    input wire logic [1:0] monitor_select_high,
    input wire logic [15:0] ref1_data,
    input wire logic [15:0] ref2_data,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic cmd_taken_r,
    output logic run_fwd_r,
    output logic run_rev_r,
    output logic fault_reset_r,
    output logic network_external_fault_r,
    output logic fault_hist_clear_r,
    output logic base_block_r,
    output logic [5:0] virtual_inputs_r,
    output logic [3:0] ref1_code_r,
    output logic [3:0] ref2_code_r,
    output logic ref1_ok_r,
    output logic ref2_ok_r,
    output logic pid_sp_enable_r,
    output logic [4:0] mon1_idx_r,
    output logic [4:0] mon2_idx_r,
    output logic mon1_ok_r,
    output logic mon2_ok_r,
    output logic [7:0] ref_echo_r,
    output logic [7:0] mon_echo_r,
    output logic [31:0] reg_rdata_r
);

    ////////////////////////////////////////////////////////////////////////////
    // command acceptance and control word masking

    logic cmd_known_w;
    logic cmd_ok_w;
    logic ext_cmd_w;
    logic [31:0] ctrl_w;
    logic fwd_bit_w;
    logic rev_bit_w;
    logic both_dir_w;

    // other command codes carry no drive control word and leave everything standing
    assign cmd_known_w = (cmd_code == dcwd_pkg::CMD_BASIC) ||
                         (cmd_code == dcwd_pkg::CMD_IO) ||
                         (cmd_code == dcwd_pkg::CMD_EXT);
    assign cmd_ok_w = cmd_valid && cmd_known_w;
    assign ext_cmd_w = (cmd_code == dcwd_pkg::CMD_EXT);
    assign ctrl_w = drive_control_word & dcwd_pkg::CTRL_USED_MASK;
    assign fwd_bit_w = ctrl_w[dcwd_pkg::BIT_FWD];
    assign rev_bit_w = ctrl_w[dcwd_pkg::BIT_REV];
    // a conflicting pair is safer as a stop than as a guessed direction
    assign both_dir_w = fwd_bit_w && rev_bit_w;

    ////////////////////////////////////////////////////////////////////////////
    // configuration register

    logic [31:0] cfg_r;
    logic [31:0] cfg_nxt;
    logic cfg_wr_w;
    logic [11:0] ao1_param_w;
    logic [11:0] ao2_param_w;
    logic s8_present_w;

    assign cfg_wr_w = reg_wr && (reg_addr == dcwd_pkg::REG_CFG);
    assign cfg_nxt = cfg_wr_w ? reg_wdata : cfg_r;
    assign ao1_param_w = cfg_r[dcwd_pkg::CFG_AO1_LSB +: dcwd_pkg::PARAM_W];
    assign ao2_param_w = cfg_r[dcwd_pkg::CFG_AO2_LSB +: dcwd_pkg::PARAM_W];
    assign s8_present_w = cfg_r[dcwd_pkg::CFG_S8_BIT];

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_r <= dcwd_pkg::CFG_RST;
        end else begin
            cfg_r <= cfg_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // run, fault and base block bits

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cmd_taken_r <= 1'b0;
            run_fwd_r <= 1'b0;
            run_rev_r <= 1'b0;
            fault_reset_r <= 1'b0;
            network_external_fault_r <= 1'b0;
            fault_hist_clear_r <= 1'b0;
            base_block_r <= 1'b0;
        end else begin
            cmd_taken_r <= cmd_ok_w;
            if (cmd_ok_w) begin
                run_fwd_r <= fwd_bit_w && !both_dir_w;
                run_rev_r <= rev_bit_w && !both_dir_w;
                fault_reset_r <= ctrl_w[dcwd_pkg::BIT_FRST];
                network_external_fault_r <= ctrl_w[dcwd_pkg::BIT_EXTF];
                fault_hist_clear_r <= ctrl_w[dcwd_pkg::BIT_HCLR];
                base_block_r <= ctrl_w[dcwd_pkg::BIT_BBLK];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // virtual input terminals three to eight

    genvar gi;
    generate
        for (gi = 0; gi < dcwd_pkg::VIN_N; gi++) begin : g_vin
            logic vin_allowed_w;
            // the eighth terminal only exists when the variant bit says so
            assign vin_allowed_w = (gi != dcwd_pkg::VIN_EIGHT) || s8_present_w;
            always_ff @(posedge mclk or negedge arst_n) begin
                if (!arst_n) begin
                    virtual_inputs_r[gi] <= 1'b0;
                end else if (cmd_ok_w) begin
                    virtual_inputs_r[gi] <= ctrl_w[dcwd_pkg::BIT_VIN_LO + gi] && vin_allowed_w;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // reference and monitor select decode, two slots each

    logic [3:0] ref_code_w [2];
    logic [15:0] ref_data_w [2];
    logic ref_ok_w [2];
    logic ref_pid_w [2];
    logic [3:0] mon_nib_w [2];
    logic mon_ok_w [2];
    logic [4:0] mon_idx_w [2];

    assign ref_data_w[0] = ref1_data;
    assign ref_data_w[1] = ref2_data;

    generate
        for (gi = 0; gi < 2; gi++) begin : g_slot
            assign ref_code_w[gi] = aux_reference_select_pair[gi*dcwd_pkg::NIB_W +: dcwd_pkg::NIB_W];
            assign mon_nib_w[gi] = monitor_value_select_pair[gi*dcwd_pkg::NIB_W +: dcwd_pkg::NIB_W];
            dcwd_ref_dec u_ref (
                .code(ref_code_w[gi]),
                .ao1_param(ao1_param_w),
                .ao2_param(ao2_param_w),
                .ref_data(ref_data_w[gi]),
                .honour(ref_ok_w[gi]),
                .pid_en(ref_pid_w[gi])
            );
            dcwd_mon_dec u_mon (
                .nib(mon_nib_w[gi]),
                .hi(monitor_select_high[gi]),
                .ext_cmd(ext_cmd_w),
                .ok(mon_ok_w[gi]),
                .idx(mon_idx_w[gi])
            );
        end
    endgenerate

    logic pid_any_w;
    assign pid_any_w = (ref_ok_w[0] && ref_pid_w[0]) || (ref_ok_w[1] && ref_pid_w[1]);

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ref1_code_r <= 4'h0;
            ref2_code_r <= 4'h0;
            ref1_ok_r <= 1'b0;
            ref2_ok_r <= 1'b0;
            pid_sp_enable_r <= 1'b0;
            mon1_idx_r <= 5'h00;
            mon2_idx_r <= 5'h00;
            mon1_ok_r <= 1'b0;
            mon2_ok_r <= 1'b0;
            ref_echo_r <= 8'h00;
            mon_echo_r <= 8'h00;
        end else if (cmd_ok_w) begin
            ref1_code_r <= ref_code_w[0];
            ref2_code_r <= ref_code_w[1];
            ref1_ok_r <= ref_ok_w[0];
            ref2_ok_r <= ref_ok_w[1];
            pid_sp_enable_r <= pid_any_w;
            mon1_idx_r <= mon_idx_w[0];
            mon2_idx_r <= mon_idx_w[1];
            mon1_ok_r <= mon_ok_w[0];
            mon2_ok_r <= mon_ok_w[1];
            // echo is the raw byte, even when a code was refused
            ref_echo_r <= aux_reference_select_pair;
            mon_echo_r <= monitor_value_select_pair;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register read port

    logic [31:0] stat_w;
    logic [31:0] echo_w;
    logic [31:0] rd_mux_w;

    assign stat_w = {5'h00, mon2_idx_r, mon1_idx_r, mon2_ok_r, mon1_ok_r, ref2_ok_r,
                     ref1_ok_r, pid_sp_enable_r, virtual_inputs_r, base_block_r,
                     fault_hist_clear_r, network_external_fault_r, fault_reset_r,
                     run_rev_r, run_fwd_r};
    assign echo_w = {16'h0000, mon_echo_r, ref_echo_r};
    assign rd_mux_w = (reg_addr == dcwd_pkg::REG_CFG) ? cfg_r :
                      (reg_addr == dcwd_pkg::REG_STAT) ? stat_w :
                      (reg_addr == dcwd_pkg::REG_ECHO) ? echo_w : 32'h0000_0000;

    // read data stand only in the cycle after the strobe, zero otherwise
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata_r <= 32'h0000_0000;
        end else begin
            reg_rdata_r <= reg_rd ? rd_mux_w : 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!arst_n);

    sequence take_s;
        cmd_ok_w ##1 cmd_taken_r;
    endsequence

    sequence take_fwd_s;
        cmd_ok_w && fwd_bit_w && !rev_bit_w;
    endsequence

    sequence idle_s;
        !cmd_ok_w;
    endsequence

    fwd_run_a: assert property (take_fwd_s |=> run_fwd_r && !run_rev_r)
        else $error("forward run not commanded");

    fwd_stop_a: assert property (cmd_ok_w && !fwd_bit_w |=> !run_fwd_r)
        else $error("forward run not removed");

    rev_run_a: assert property (cmd_ok_w && rev_bit_w && !fwd_bit_w |=> run_rev_r)
        else $error("reverse run not commanded");

    fault_bits_a: assert property (take_s |->
        fault_reset_r == $past(drive_control_word[dcwd_pkg::BIT_FRST], 1) &&
        network_external_fault_r == $past(drive_control_word[dcwd_pkg::BIT_EXTF], 1))
        else $error("fault reset or external fault mismatch");

    hist_clear_a: assert property (cmd_ok_w && drive_control_word[dcwd_pkg::BIT_HCLR]
        |=> fault_hist_clear_r)
        else $error("fault history clear missing");

    base_block_a: assert property (take_s ##0 idle_s [*2] |->
        base_block_r == $past(drive_control_word[dcwd_pkg::BIT_BBLK], 2))
        else $error("base block changed without a command");

    vin_map_a: assert property (take_s |->
        virtual_inputs_r[4:0] == $past(drive_control_word[20:16], 1))
        else $error("virtual inputs three to seven mismatch");

    vin_eight_a: assert property (cmd_ok_w && !s8_present_w |=> !virtual_inputs_r[5])
        else $error("eighth input driven on a variant without it");

    ref_aout_a: assert property (cmd_ok_w && ref_code_w[0] == dcwd_pkg::REF_AOUT1 &&
        ao1_param_w != dcwd_pkg::AOUT_PARAM_FREE |=> !ref1_ok_r)
        else $error("analog output reference honoured while parameter busy");

    mon_ext_a: assert property (cmd_ok_w && !ext_cmd_w && monitor_select_high[0]
        |=> !mon1_ok_r && mon1_idx_r == 5'h00)
        else $error("extended monitor code accepted outside extended command");

    echo_a: assert property (cmd_ok_w ##1 idle_s |->
        ref_echo_r == $past(aux_reference_select_pair, 1) &&
        mon_echo_r == $past(monitor_value_select_pair, 1))
        else $error("select bytes not echoed");

    stop_both_a: assert property (cmd_ok_w && both_dir_w |=> !run_fwd_r && !run_rev_r)
        else $error("conflicting directions not stopped");

    reserved_a: assert property (take_s |->
        stat_w[5:0] == {$past(drive_control_word[12:9], 1) == 4'h0 ? 4'h0 : stat_w[5:2],
                        stat_w[1:0]})
        else $error("reserved bits disturbed control outputs");

    read_lat_a: assert property (reg_rd && reg_addr == dcwd_pkg::REG_STAT ##1 idle_s
        |-> reg_rdata_r == $past(stat_w, 1))
        else $error("status read data wrong or late");

    read_zero_a: assert property (!reg_rd |=> reg_rdata_r == 32'h0000_0000)
        else $error("read data present without a read strobe");

    ////////////////////////////////////////////////////////////////////////////
    // hold behaviour, slot two and the configuration port

    sequence take_ext_hi2_s;
        cmd_ok_w && ext_cmd_w && monitor_select_high[1];
    endsequence

    sequence take_lo2_s;
        cmd_ok_w && !monitor_select_high[1];
    endsequence

    rev_stop_a: assert property (cmd_ok_w && !rev_bit_w |=> !run_rev_r)
        else $error("reverse run not removed");

    taken_pulse_a: assert property (idle_s |=> !cmd_taken_r)
        else $error("command taken pulse without a command");

    hold_a: assert property (idle_s |=> $stable(run_fwd_r) && $stable(run_rev_r) &&
        $stable(base_block_r) && $stable(virtual_inputs_r) && $stable(ref_echo_r))
        else $error("decoded outputs moved without a command");

    vin_eight_on_a: assert property (cmd_ok_w && s8_present_w |=>
        virtual_inputs_r[dcwd_pkg::VIN_EIGHT] ==
        $past(drive_control_word[dcwd_pkg::BIT_VIN_LO + dcwd_pkg::VIN_EIGHT], 1))
        else $error("eighth input does not follow its bit");

    ref_aout2_a: assert property (cmd_ok_w && ref_code_w[1] == dcwd_pkg::REF_AOUT2 &&
        ao2_param_w != dcwd_pkg::AOUT_PARAM_FREE |=> !ref2_ok_r)
        else $error("second analog reference honoured while parameter busy");

    ref_free_a: assert property (cmd_ok_w && ref_code_w[0] == dcwd_pkg::REF_AOUT1 &&
        ao1_param_w == dcwd_pkg::AOUT_PARAM_FREE |=> ref1_ok_r)
        else $error("analog reference refused while parameter free");

    pid_en_a: assert property (cmd_ok_w && ref_code_w[0] == dcwd_pkg::REF_CMD_SEL &&
        ref1_data[dcwd_pkg::PID_EN_BIT] |=> pid_sp_enable_r)
        else $error("setpoint enable not raised");

    ref_code_a: assert property (take_s |->
        {ref2_code_r, ref1_code_r} == $past(aux_reference_select_pair, 1))
        else $error("reference slot codes swapped or lost");

    mon_basic_a: assert property (take_lo2_s |=> mon2_ok_r &&
        mon2_idx_r == $past({1'b0, mon_nib_w[1]}, 1))
        else $error("basic monitor code not accepted");

    mon_ext_ok_a: assert property (take_ext_hi2_s ##0
        {1'b1, mon_nib_w[1]} <= dcwd_pkg::MON_LAST_EXT |=> mon2_ok_r && mon2_idx_r[4])
        else $error("extended monitor code refused in extended command");

    mon_far_a: assert property (take_ext_hi2_s ##0
        {1'b1, mon_nib_w[1]} > dcwd_pkg::MON_LAST_EXT |=> !mon2_ok_r && mon2_idx_r == 5'h00)
        else $error("monitor code beyond the extended block accepted");

    mon2_ext_a: assert property (cmd_ok_w && !ext_cmd_w && monitor_select_high[1]
        |=> !mon2_ok_r)
        else $error("extended code in slot two accepted outside extended command");

    cfg_write_a: assert property (reg_wr && reg_addr == dcwd_pkg::REG_CFG |=>
        cfg_r == $past(reg_wdata, 1))
        else $error("configuration write lost");

endmodule : dcwd_top
`default_nettype wire

/* dv/dcwd_net_master.sv */
// network master model: issues cyclic drive commands to the decoder
`timescale 1ns/1ps
`default_nettype none
module dcwd_net_master (
    input wire logic mclk,
    output logic cmd_valid,
    output logic [7:0] cmd_code,
    output logic [31:0] drive_control_word,
    output logic [7:0] aux_reference_select_pair,
    output logic [7:0] monitor_value_select_pair,
    output logic [1:0] monitor_select_high,
    output logic [15:0] ref1_data,
    output logic [15:0] ref2_data
);
    initial begin
        cmd_valid = 1'b0;
        cmd_code = 8'h00;
        drive_control_word = 32'h0000_0000;
        aux_reference_select_pair = 8'h00;
        monitor_value_select_pair = 8'h00;
        monitor_select_high = 2'h0;
        ref1_data = 16'h0000;
        ref2_data = 16'h0000;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // fields are inverted once the command is gone, so a stale value is never trusted
    task automatic send(input logic [7:0] code, input logic [31:0] word, input logic [7:0] rsel,
        input logic [7:0] msel, input logic [1:0] hi, input logic [15:0] d1);
        @(posedge mclk);
        cmd_valid <= 1'b1;
        cmd_code <= code;
        drive_control_word <= word;
        aux_reference_select_pair <= rsel;
        monitor_value_select_pair <= msel;
        monitor_select_high <= hi;
        ref1_data <= d1;
        ref2_data <= 16'h0000;
        @(posedge mclk);
        cmd_valid <= 1'b0;
        cmd_code <= ~code;
        drive_control_word <= ~word;
        aux_reference_select_pair <= ~rsel;
        monitor_value_select_pair <= ~msel;
        monitor_select_high <= ~hi;
        ref1_data <= ~d1;
        ref2_data <= 16'hffff;
    endtask : send
endmodule : dcwd_net_master
`default_nettype wire

/* dv/dcwd_top_test.sv */
// self-checking testbench of the drive command word decoder
`timescale 1ns/1ps
`default_nettype none
module dcwd_top_test;
    logic mclk;
    logic arst_n;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic cmd_valid, cmd_taken_r, run_fwd_r, run_rev_r, fault_reset_r;
    logic network_external_fault_r, fault_hist_clear_r, base_block_r;
    logic ref1_ok_r, ref2_ok_r, pid_sp_enable_r, mon1_ok_r, mon2_ok_r;
    logic [7:0] cmd_code, rsel, msel, ref_echo_r, mon_echo_r;
    logic [31:0] dcw, reg_rdata_r, rd;
    logic [1:0] mhi;
    logic [15:0] d1, d2;
    logic [5:0] virtual_inputs_r;
    logic [3:0] ref1_code_r, ref2_code_r;
    logic [4:0] mon1_idx_r, mon2_idx_r;
    logic [31:0] ctl_seen, ref_seen, mon_seen;
    int errors;
    int total_checks;
    assign ctl_seen = {19'h0, cmd_taken_r, virtual_inputs_r, run_fwd_r, run_rev_r,
        fault_reset_r, network_external_fault_r, fault_hist_clear_r, base_block_r};
    assign ref_seen = {13'h0, ref_echo_r, ref1_code_r, ref2_code_r, ref1_ok_r, ref2_ok_r,
        pid_sp_enable_r};
    assign mon_seen = {12'h0, mon_echo_r, mon1_idx_r, mon2_idx_r, mon1_ok_r, mon2_ok_r};

    dcwd_net_master master_u (.mclk(mclk), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .drive_control_word(dcw), .aux_reference_select_pair(rsel),
        .monitor_value_select_pair(msel), .monitor_select_high(mhi), .ref1_data(d1),
        .ref2_data(d2));
    dcwd_top dut_u (.mclk(mclk), .arst_n(arst_n), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .drive_control_word(dcw), .aux_reference_select_pair(rsel),
        .monitor_value_select_pair(msel), .monitor_select_high(mhi), .ref1_data(d1),
        .ref2_data(d2), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .cmd_taken_r(cmd_taken_r), .run_fwd_r(run_fwd_r),
        .run_rev_r(run_rev_r), .fault_reset_r(fault_reset_r),
        .network_external_fault_r(network_external_fault_r),
        .fault_hist_clear_r(fault_hist_clear_r), .base_block_r(base_block_r),
        .virtual_inputs_r(virtual_inputs_r), .ref1_code_r(ref1_code_r),
        .ref2_code_r(ref2_code_r), .ref1_ok_r(ref1_ok_r), .ref2_ok_r(ref2_ok_r),
        .pid_sp_enable_r(pid_sp_enable_r), .mon1_idx_r(mon1_idx_r), .mon2_idx_r(mon2_idx_r),
        .mon1_ok_r(mon1_ok_r), .mon2_ok_r(mon2_ok_r), .ref_echo_r(ref_echo_r),
        .mon_echo_r(mon_echo_r), .reg_rdata_r(reg_rdata_r));

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : reg_write

    // read data is looked at in the single cycle where it stands
    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata_r;
    endtask : reg_read

    // command taken, then outputs sampled just after the answering edge
    task automatic cmd(input logic [7:0] c, input logic [31:0] w, input logic [7:0] r,
        input logic [7:0] m, input logic [1:0] h, input logic [15:0] pd);
        master_u.send(c, w, r, m, h, pd);
        #1;
    endtask : cmd

    task automatic conclude();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : conclude
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk(ctl_seen | ref_seen | mon_seen, 32'h0000_0000);
        reg_read(8'h00, rd);
        chk(rd, 32'h0000_0000);
        reg_write(8'h0c, 32'hffff_ffff);
        reg_read(8'h0c, rd);
        chk(rd, 32'h0000_0000);
    endtask : t_reset

    task automatic t_ctrl();
        cmd(8'h50, 32'hffff_fffe, 8'h00, 8'h00, 2'h0, 16'h0);
        chk(ctl_seen, {19'h0, 1'b1, 6'h1f, 6'b011111});
        @(posedge mclk);
        #1 chk(ctl_seen, {19'h0, 1'b0, 6'h1f, 6'b011111});
        cmd(8'h51, 32'h0000_0002, 8'h00, 8'h00, 2'h0, 16'h0);
        chk(ctl_seen, {19'h0, 1'b1, 6'h00, 6'b010000});
        cmd(8'h52, 32'h0000_0003, 8'h00, 8'h00, 2'h0, 16'h0);
        chk(ctl_seen, {19'h0, 1'b1, 6'h00, 6'b000000});
        cmd(8'h53, 32'h0000_0001, 8'h00, 8'h00, 2'h0, 16'h0);
        chk(ctl_seen, 32'h0000_0000);
        reg_write(8'h00, 32'h0100_0000);
        cmd(8'h50, 32'h0020_0000, 8'h00, 8'h00, 2'h0, 16'h0);
        chk(ctl_seen, {19'h0, 1'b1, 6'h20, 6'b000000});
        cmd(8'h50, 32'h0015_0201, 8'h00, 8'h00, 2'h0, 16'h0);
        chk(ctl_seen, {19'h0, 1'b1, 6'h15, 6'b101000});
        reg_read(8'h04, rd);
        chk(rd, 32'h0001_e545);
        @(posedge mclk);
        #1 chk(reg_rdata_r, 32'h0000_0000);
    endtask : t_ctrl

    task automatic t_ref();
        logic [3:0] c;
        logic ok;
        reg_write(8'h00, 32'h0000_0000);
        for (int i = 0; i < 10; i++) begin
            c = 4'(i);
            ok = (i != 8);
            cmd(8'h50, 32'h0, {c, c}, 8'h00, 2'h0, 16'h0002);
            chk(ref_seen, {13'h0, c, c, c, c, ok, ok, i == 9});
        end
        cmd(8'h50, 32'h0, 8'h09, 8'h00, 2'h0, 16'hfffd);
        chk(ref_seen, {13'h0, 8'h09, 8'h90, 3'b110});
        reg_write(8'h00, 32'h0000_0001);
        cmd(8'h50, 32'h0, 8'h32, 8'h00, 2'h0, 16'h0);
        chk(ref_seen, {13'h0, 8'h32, 8'h23, 3'b010});
        reg_write(8'h00, 32'h0080_0000);
        cmd(8'h51, 32'h0, 8'h32, 8'h00, 2'h0, 16'h0);
        chk(ref_seen, {13'h0, 8'h32, 8'h23, 3'b100});
        reg_read(8'h08, rd);
        chk(rd, 32'h0000_0032);
    endtask : t_ref

    task automatic t_mon();
        logic [4:0] c;
        logic ok;
        for (int i = 0; i < 24; i++) begin
            c = 5'(i);
            ok = (i <= 22);
            cmd(8'h52, 32'h0, 8'h00, {c[3:0], c[3:0]}, {c[4], c[4]}, 16'h0);
            chk(mon_seen, {12'h0, {2{c[3:0]}}, ok ? {c, c} : 10'h0, ok, ok});
        end
        cmd(8'h50, 32'h0, 8'h00, 8'h00, 2'h3, 16'h0);
        chk(mon_seen, {12'h0, 8'h00, 10'h0, 2'b00});
        cmd(8'h51, 32'h0, 8'h00, 8'h3f, 2'h1, 16'h0);
        chk(mon_seen, {12'h0, 8'h3f, 5'h00, 5'h03, 2'b01});
        cmd(8'h52, 32'h0, 8'h00, 8'h3a, 2'h2, 16'h0);
        chk(mon_seen, {12'h0, 8'h3a, 5'h0a, 5'h13, 2'b11});
    endtask : t_mon
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        errors = 0;
        total_checks = 0;
        arst_n = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (5) @(posedge mclk);
        arst_n <= 1'b1;
        t_reset();
        t_ctrl();
        t_ref();
        t_mon();
        conclude();
    end

    // the sequence needs well under 500 cycles
    initial begin
        #100000;
        errors++;
        conclude();
    end
endmodule : dcwd_top_test
`default_nettype wire
